// >>> logic/ddso_card_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module ddso_card_ctrl
	import ddso_pkg::*;
(
	// clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_rst,
	// card status
	input  wire logic i_card_present,
	input  wire logic i_card_empty,
	input  wire logic i_card_differs,
	input  wire logic i_xfer_done,
	// transfer commands
	output logic      o_copy_to_dev,
	output logic      o_copy_to_card
);

	ddso_card_t state_q;

	// ------------------------------------------------------------
	// one transfer per card insertion
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= DDSO_CARD_IDLE;
		end else begin
			case (state_q)
				DDSO_CARD_IDLE: begin
					if (i_card_present && i_card_empty) begin
						state_q <= DDSO_CARD_TO_CARD; // R12
					end else if (i_card_present && i_card_differs) begin
						state_q <= DDSO_CARD_TO_DEV; // R11
					end else if (i_card_present) begin
						state_q <= DDSO_CARD_DONE;
					end
				end
				DDSO_CARD_TO_DEV, DDSO_CARD_TO_CARD: begin
					if (!i_card_present || i_xfer_done) begin
						state_q <= DDSO_CARD_DONE;
					end
				end
				DDSO_CARD_DONE: begin
					// wait for removal, avoids copy loops
					if (!i_card_present) begin
						state_q <= DDSO_CARD_IDLE;
					end
				end
				default: begin
					state_q <= DDSO_CARD_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_copy_to_dev  <= 1'b0;
			o_copy_to_card <= 1'b0;
		end else begin
			o_copy_to_dev  <= (state_q == DDSO_CARD_TO_DEV) &&
				i_card_present && !i_xfer_done;
			o_copy_to_card <= (state_q == DDSO_CARD_TO_CARD) &&
				i_card_present && !i_xfer_done;
		end
	end

endmodule

`default_nettype wire

// >>> logic/ddso_code_match.sv
`timescale 1ns/10ps
`default_nettype none

module ddso_code_match
	import ddso_pkg::*;
(
	// selected codes
	input  wire logic [15:0] i_code_a,
	input  wire logic [15:0] i_code_b,
	// detected error
	input  wire logic        i_err_valid,
	input  wire logic [15:0] i_err_code,
	input  wire logic        i_class_ok,
	// result
	output logic             o_hit
);

	function automatic logic code_hit(input logic [15:0] sel,
		input logic [15:0] code);
		// zero means unused slot
		code_hit = (sel != DDSO_CODE_NONE) && (sel == code);
	endfunction

	// live compare, so a new code acts at once
	assign o_hit = i_err_valid && i_class_ok &&
		(code_hit(i_code_a, i_err_code) ||
		code_hit(i_code_b, i_err_code)); // R6 R9 R13

endmodule

`default_nettype wire

// >>> logic/ddso_pkg.sv
package ddso_pkg;

	// ------------------------------------------------------------
	// register map (parameter addresses)
	// ------------------------------------------------------------
	localparam logic [15:0] DDSO_ADDR_SEL_ERR_A  = 16'h3b0c;
	localparam logic [15:0] DDSO_ADDR_SEL_ERR_B  = 16'h3b0e;
	localparam logic [15:0] DDSO_ADDR_SEL_WARN_A = 16'h3b10;
	localparam logic [15:0] DDSO_ADDR_SEL_WARN_B = 16'h3b12;
	localparam logic [15:0] DDSO_CODE_RESET      = 16'h0000;
	localparam logic [15:0] DDSO_CODE_NONE       = 16'h0000;

	// ------------------------------------------------------------
	// operating states and error classes
	// ------------------------------------------------------------
	localparam logic [3:0] DDSO_ST_READY    = 4'h4;
	localparam logic [3:0] DDSO_ST_ON       = 4'h5;
	localparam logic [3:0] DDSO_ST_ENABLED  = 4'h6;
	localparam logic [2:0] DDSO_CLASS_WARN  = 3'h0;
	localparam logic [2:0] DDSO_CLASS_MAX   = 3'h4;

	// ------------------------------------------------------------
	// output function selection
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		DDSO_FN_NO_FAULT = 3'h0,
		DDSO_FN_ACTIVE   = 3'h1,
		DDSO_FN_SEL_WARN = 3'h2,
		DDSO_FN_SEL_ERR  = 3'h3,
		DDSO_FN_DC_BUS   = 3'h4,
		DDSO_FN_OFF      = 3'h5
	} ddso_fn_t;

	localparam ddso_fn_t DDSO_FN_ZERO_RESET = DDSO_FN_NO_FAULT;
	localparam ddso_fn_t DDSO_FN_ONE_RESET  = DDSO_FN_ACTIVE;

	// ------------------------------------------------------------
	// memory card transfer machine
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		DDSO_CARD_IDLE    = 4'b0001,
		DDSO_CARD_TO_DEV  = 4'b0010,
		DDSO_CARD_TO_CARD = 4'b0100,
		DDSO_CARD_DONE    = 4'b1000
	} ddso_card_t;

endpackage

// >>> logic/ddso_top.sv
// How it works
// (R1) no-fault is 1 only in operating states 4, 5 and 6.
// (R2) active is 1 only in state 6 and is the reset function of output one.
// (R3) output zero carries the no-fault function after reset.
// (R4) two selected-warning codes match errors of class 0.
// (R5) two selected-error codes match errors of classes 1 to 4.
// (R6) a matching detected error sets the outputs assigned to that function.
// (R7) software must assign a selected function to an output to see it.
// (R8) each selected code is 16 bits with reset value 0.
// (R9) a written code is used for matching at once.
// (R10) the dc bus indicator lights while voltage is present.
// (R11) a differing card is copied into the device unless it is also empty, which R12 then covers.
// (R12) an empty card receives the device configuration.
// (R13) no match, or both codes 0, keeps the selected output low.
`timescale 1ns/10ps
`default_nettype none

module ddso_top
	import ddso_pkg::*;
(
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst,
	// parameter access
	input  wire logic        i_par_wr,
	input  wire logic [15:0] i_par_addr,
	input  wire logic [15:0] i_par_wdata,
	output logic      [15:0] o_par_rdata,
	output logic             o_par_hit,
	// output function assignment
	input  wire logic        i_fn_wr,
	input  wire logic        i_fn_sel,
	input  wire logic [2:0]  i_fn_value,
	// drive state
	input  wire logic [3:0]  i_op_state,
	input  wire logic        i_err_valid,
	input  wire logic [15:0] i_err_code,
	input  wire logic [2:0]  i_err_class,
	input  wire logic        i_dc_bus_ok,
	// memory card
	input  wire logic        i_card_present,
	input  wire logic        i_card_empty,
	input  wire logic        i_card_differs,
	input  wire logic        i_xfer_done,
	output logic             o_copy_to_dev,
	output logic             o_copy_to_card,
	// signal outputs
	output logic             o_digital_output_zero,
	output logic             o_digital_output_one,
	output logic             o_dc_bus_led
);

	logic [15:0] sel_warn_a_q;
	logic [15:0] sel_warn_b_q;
	logic [15:0] sel_err_a_q;
	logic [15:0] sel_err_b_q;
	ddso_fn_t    fn_zero_q;
	ddso_fn_t    fn_one_q;
	logic        warn_hit;
	logic        err_hit;
	logic        class_warn;
	logic        class_err;

	// ------------------------------------------------------------
	// selected code registers
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			sel_err_a_q  <= DDSO_CODE_RESET; // R8
			sel_err_b_q  <= DDSO_CODE_RESET;
			sel_warn_a_q <= DDSO_CODE_RESET;
			sel_warn_b_q <= DDSO_CODE_RESET;
		end else if (i_par_wr) begin
			case (i_par_addr)
				DDSO_ADDR_SEL_ERR_A:  sel_err_a_q  <= i_par_wdata;
				DDSO_ADDR_SEL_ERR_B:  sel_err_b_q  <= i_par_wdata;
				DDSO_ADDR_SEL_WARN_A: sel_warn_a_q <= i_par_wdata;
				DDSO_ADDR_SEL_WARN_B: sel_warn_b_q <= i_par_wdata;
				default: begin
				end
			endcase
		end
	end

	// combinational read; unmapped reads zero with no hit
	always_comb begin
		o_par_rdata = DDSO_CODE_NONE;
		o_par_hit   = 1'b1;
		case (i_par_addr)
			DDSO_ADDR_SEL_ERR_A:  o_par_rdata = sel_err_a_q;
			DDSO_ADDR_SEL_ERR_B:  o_par_rdata = sel_err_b_q;
			DDSO_ADDR_SEL_WARN_A: o_par_rdata = sel_warn_a_q;
			DDSO_ADDR_SEL_WARN_B: o_par_rdata = sel_warn_b_q;
			default:              o_par_hit   = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// output function assignment
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			fn_zero_q <= DDSO_FN_ZERO_RESET; // R3
			fn_one_q  <= DDSO_FN_ONE_RESET; // R2
		end else if (i_fn_wr && (i_fn_value <= DDSO_FN_OFF)) begin
			// R7
			if (i_fn_sel) begin
				fn_one_q <= ddso_fn_t'(i_fn_value);
			end else begin
				fn_zero_q <= ddso_fn_t'(i_fn_value);
			end
		end
	end

	// ------------------------------------------------------------
	// error code matching
	// ------------------------------------------------------------
	assign class_warn = (i_err_class == DDSO_CLASS_WARN); // R4
	assign class_err  = (i_err_class != DDSO_CLASS_WARN) &&
		(i_err_class <= DDSO_CLASS_MAX); // R5

	ddso_code_match u_warn_match (
		.i_code_a    (sel_warn_a_q),
		.i_code_b    (sel_warn_b_q),
		.i_err_valid (i_err_valid),
		.i_err_code  (i_err_code),
		.i_class_ok  (class_warn),
		.o_hit       (warn_hit)
	);

	ddso_code_match u_err_match (
		.i_code_a    (sel_err_a_q),
		.i_code_b    (sel_err_b_q),
		.i_err_valid (i_err_valid),
		.i_err_code  (i_err_code),
		.i_class_ok  (class_err),
		.o_hit       (err_hit)
	);

	// ------------------------------------------------------------
	// signal outputs
	// ------------------------------------------------------------
	function automatic logic fn_level(input ddso_fn_t fn,
		input logic [3:0] st, input logic w, input logic e,
		input logic dc);
		case (fn)
			DDSO_FN_NO_FAULT: fn_level = (st == DDSO_ST_READY) ||
				(st == DDSO_ST_ON) || (st == DDSO_ST_ENABLED); // R1
			DDSO_FN_ACTIVE:   fn_level = (st == DDSO_ST_ENABLED); // R2
			DDSO_FN_SEL_WARN: fn_level = w; // R6
			DDSO_FN_SEL_ERR:  fn_level = e; // R6
			DDSO_FN_DC_BUS:   fn_level = dc;
			default:          fn_level = 1'b0;
		endcase
	endfunction

	// registered so pins never glitch on decode
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_digital_output_zero <= 1'b0;
			o_digital_output_one  <= 1'b0;
		end else begin
			o_digital_output_zero <= fn_level(fn_zero_q, i_op_state,
				warn_hit, err_hit, i_dc_bus_ok);
			o_digital_output_one  <= fn_level(fn_one_q, i_op_state,
				warn_hit, err_hit, i_dc_bus_ok);
		end
	end

	// dark led does not prove the bus is discharged
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_dc_bus_led <= 1'b0;
		end else begin
			o_dc_bus_led <= i_dc_bus_ok; // R10
		end
	end

	// ------------------------------------------------------------
	// memory card transfers
	// ------------------------------------------------------------
	ddso_card_ctrl u_card (
		.i_sys_clk      (i_sys_clk),
		.i_rst          (i_rst),
		.i_card_present (i_card_present),
		.i_card_empty   (i_card_empty),
		.i_card_differs (i_card_differs),
		.i_xfer_done    (i_xfer_done),
		.o_copy_to_dev  (o_copy_to_dev),
		.o_copy_to_card (o_copy_to_card)
	);

endmodule

`default_nettype wire

// >>> testbench/ddso_plc_model.sv
`timescale 1ns/10ps
`default_nettype none
module ddso_plc_model (
	// clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst,
	// watched signal output
	input  wire logic       i_active,
	// switch-on events seen
	output logic      [7:0] o_rises
);
	logic last_q;
	// a plc input counts edges, so a glitch shows up
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			last_q  <= 1'h0;
			o_rises <= 8'h00;
		end else begin
			last_q <= i_active;
			if (i_active && !last_q) o_rises <= o_rises + 8'h01;
		end
	end
endmodule
`default_nettype wire

// >>> testbench/ddso_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
module ddso_top_chk
	import ddso_pkg::*;
(
	input wire logic        i_sys_clk, i_rst, i_par_wr, i_fn_wr, i_fn_sel,
	input wire logic        i_err_valid, i_card_present, i_card_empty,
	input wire logic        i_card_differs, i_xfer_done, o_par_hit,
	input wire logic        o_copy_to_dev, o_copy_to_card,
	input wire logic        o_digital_output_zero, o_digital_output_one,
	input wire logic [15:0] i_par_addr, i_par_wdata, o_par_rdata, i_err_code,
	input wire logic [2:0]  i_fn_value,
	input wire logic [3:0]  i_op_state
);
	logic     up_q;
	ddso_fn_t fn0_q, fn1_q;
	always_ff @(posedge i_sys_clk or posedge i_rst)
		if (i_rst) up_q <= 1'h0;
		else up_q <= 1'h1;
	// selector mirror; values 6 and 7 are dropped
	always_ff @(posedge i_sys_clk or posedge i_rst)
		if (i_rst) begin
			fn0_q <= DDSO_FN_ZERO_RESET;
			fn1_q <= DDSO_FN_ONE_RESET;
		end else if (i_fn_wr && i_fn_value <= 3'h5) begin
			if (i_fn_sel) fn1_q <= ddso_fn_t'(i_fn_value);
			else fn0_q <= ddso_fn_t'(i_fn_value);
		end
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst || !up_q);
	sequence s_gap;
		(!i_card_present) [*3];
	endsequence
	sequence s_hold;
		(i_card_present && !i_xfer_done) [*4];
	endsequence
	a_par_zero: assert property (
		!o_par_hit |-> o_par_rdata == 16'h0000) else $error("unmapped read");
	a_par_readback: assert property (
		i_par_wr && o_par_hit |=> i_par_addr != $past(i_par_addr)
		|| o_par_rdata == $past(i_par_wdata)) else $error("readback");
	a_no_fault_map: assert property (
		fn0_q == DDSO_FN_NO_FAULT |=> o_digital_output_zero
		== ($past(i_op_state) inside {4'h4, 4'h5, 4'h6})) else $error("nf");
	a_active_map: assert property (
		fn1_q == DDSO_FN_ACTIVE |=> o_digital_output_one
		== ($past(i_op_state) == DDSO_ST_ENABLED)) else $error("active");
	a_sel_idle: assert property (
		fn0_q == DDSO_FN_SEL_WARN && (!i_err_valid || i_err_code == 16'h0000)
		|=> !o_digital_output_zero) else $error("sel idle");
	a_card_drop: assert property (
		(o_copy_to_card || o_copy_to_dev) && (i_xfer_done || !i_card_present)
		|-> ##1 !(o_copy_to_card || o_copy_to_dev)) else $error("drop");
	a_card_empty: assert property (
		s_gap ##1 (i_card_empty ##0 s_hold) |-> o_copy_to_card)
		else $error("empty card");
	a_card_differs: assert property (
		s_gap ##1 (!i_card_empty && i_card_differs ##0 s_hold)
		|-> o_copy_to_dev) else $error("differs");
endmodule
bind ddso_top ddso_top_chk u_chk (.*);
`default_nettype wire

// >>> testbench/test_drive_diag_signal_outputs.sv
`timescale 1ns/10ps
`default_nettype none
module test_drive_diag_signal_outputs;
	import ddso_pkg::*;
	logic        i_sys_clk = 1'h0, i_rst = 1'h1, i_par_wr = 1'h0;
	logic        i_fn_wr = 1'h0, i_fn_sel = 1'h0, i_err_valid = 1'h0;
	logic        i_dc_bus_ok = 1'h0, i_xfer_done = 1'h0, i_card_empty = 1'h0;
	logic        i_card_present = 1'h0, i_card_differs = 1'h0;
	logic        o_par_hit, o_dc_bus_led, o_copy_to_dev, o_copy_to_card;
	logic        o_digital_output_zero, o_digital_output_one;
	logic [15:0] i_par_addr = 16'h0000, i_par_wdata = 16'h0000;
	logic [15:0] i_err_code = 16'h0000, o_par_rdata;
	logic [2:0]  i_fn_value = 3'h0, i_err_class = 3'h0;
	logic [3:0]  i_op_state = 4'h1;
	logic [7:0]  rises;
	int          err_total = 0;
	int          comparisons = 0;
	ddso_top dut (.*);
	ddso_plc_model plc (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
		.i_active(o_digital_output_one), .o_rises(rises));
	initial forever #2.5 i_sys_clk = ~i_sys_clk;
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic tk(int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask
	task automatic wr(logic [15:0] a, logic [15:0] d);
		@(posedge i_sys_clk);
		i_par_wr <= 1'h1;
		i_par_addr <= a;
		i_par_wdata <= d;
		@(posedge i_sys_clk);
		i_par_wr <= 1'h0;
	endtask
	task automatic fn(logic s, logic [2:0] v);
		@(posedge i_sys_clk);
		i_fn_wr <= 1'h1;
		i_fn_sel <= s;
		i_fn_value <= v;
		@(posedge i_sys_clk);
		i_fn_wr <= 1'h0;
	endtask
	task automatic rdc(logic [15:0] a, logic [15:0] e, logic h);
		@(posedge i_sys_clk);
		i_par_addr <= a;
		#1;
		chk("rdata", e, o_par_rdata);
		chk("hit", {15'h0000, h}, {15'h0000, o_par_hit});
	endtask
	task automatic ev(logic [15:0] c, logic [2:0] k, logic [1:0] e);
		@(posedge i_sys_clk);
		i_err_valid <= 1'h1;
		i_err_code <= c;
		i_err_class <= k;
		tk(1);
		chk("outs", e, {o_digital_output_zero, o_digital_output_one});
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		logic [15:0] ad [4];
		ad = '{DDSO_ADDR_SEL_ERR_A, DDSO_ADDR_SEL_ERR_B,
			DDSO_ADDR_SEL_WARN_A, DDSO_ADDR_SEL_WARN_B};
		foreach (ad[i]) rdc(ad[i], 16'h0000, 1'h1);
		foreach (ad[i]) wr(ad[i], 16'hfff0 + 16'(i));
		foreach (ad[i]) rdc(ad[i], 16'hfff0 + 16'(i), 1'h1);
		wr(16'h3b14, 16'h5555);
		rdc(16'h3b14, 16'h0000, 1'h0);
	endtask
	task automatic t_states;
		for (int s = 1; s <= 9; s++) begin
			@(posedge i_sys_clk);
			i_op_state <= 4'(s);
			i_dc_bus_ok <= s[0];
			tk(1);
			chk("out0", s inside {4, 5, 6}, o_digital_output_zero);
			chk("out1", s == 6, o_digital_output_one);
			chk("led", s[0], o_dc_bus_led);
		end
		chk("rises", 16'h0001, rises);
	endtask
	task automatic t_sel;
		fn(1'h0, DDSO_FN_SEL_WARN);
		fn(1'h1, DDSO_FN_SEL_ERR);
		wr(DDSO_ADDR_SEL_WARN_A, 16'h0000);
		wr(DDSO_ADDR_SEL_WARN_B, 16'h1234);
		wr(DDSO_ADDR_SEL_ERR_A, 16'hffff);
		wr(DDSO_ADDR_SEL_ERR_B, 16'h0000);
		ev(16'h1234, 3'h0, 2'h2);
		ev(16'h1234, 3'h2, 2'h0);
		ev(16'hffff, 3'h4, 2'h1);
		ev(16'hffff, 3'h1, 2'h1);
		ev(16'hffff, 3'h0, 2'h0);
		ev(16'h0000, 3'h0, 2'h0);
		ev(16'h0042, 3'h3, 2'h0);
		wr(DDSO_ADDR_SEL_ERR_B, 16'h0042);
		tk(1);
		chk("out1", 16'h0001, o_digital_output_one);
		wr(DDSO_ADDR_SEL_ERR_A, 16'h0000);
		wr(DDSO_ADDR_SEL_ERR_B, 16'h0000);
		ev(16'h0000, 3'h3, 2'h0);
	endtask
	task automatic t_fn;
		logic [7:0] exp_bits;
		exp_bits = 8'hd5;
		@(posedge i_sys_clk);
		i_op_state <= DDSO_ST_READY;
		i_err_code <= 16'h1234;
		i_err_class <= 3'h0;
		i_dc_bus_ok <= 1'h1;
		for (int v = 0; v < 8; v++) begin
			fn(1'h1, DDSO_FN_DC_BUS);
			fn(1'h1, 3'(v));
			tk(1);
			chk("fn", exp_bits[v], o_digital_output_one);
		end
	endtask
	task automatic t_card;
		@(posedge i_sys_clk);
		i_card_present <= 1'h1;
		i_card_empty <= 1'h1;
		i_card_differs <= 1'h1;
		tk(3);
		chk("copy", 2'h2, {o_copy_to_card, o_copy_to_dev});
		@(posedge i_sys_clk);
		i_xfer_done <= 1'h1;
		tk(2);
		chk("copy", 2'h0, {o_copy_to_card, o_copy_to_dev});
		@(posedge i_sys_clk);
		i_xfer_done <= 1'h0;
		tk(3);
		chk("once", 2'h0, {o_copy_to_card, o_copy_to_dev});
		@(posedge i_sys_clk);
		i_card_present <= 1'h0;
		i_card_empty <= 1'h0;
		tk(3);
		@(posedge i_sys_clk);
		i_card_present <= 1'h1;
		tk(3);
		chk("copy", 2'h1, {o_copy_to_card, o_copy_to_dev});
		@(posedge i_sys_clk);
		i_card_present <= 1'h0;
		tk(2);
		chk("copy", 2'h0, {o_copy_to_card, o_copy_to_dev});
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge i_sys_clk);
		i_rst <= 1'h0;
		t_regs;
		t_states;
		t_sel;
		t_fn;
		t_card;
		tally_and_finish;
	end
	// whole run is well under a thousand cycles
	initial begin
		repeat (4000) @(posedge i_sys_clk);
		err_total++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
